// [logic/pwf_map.svh]
// register offsets, field positions and reset values of the wake filter
`ifndef PWF_MAP_SVH
`define PWF_MAP_SVH
`define PWF_ADDR_W          7
`define PWF_OFF_MASK_HI     7'h27
`define PWF_OFF_MASK_MIDHI  7'h28
`define PWF_OFF_MASK_MIDLO  7'h29
`define PWF_OFF_MASK_LO     7'h2A
`define PWF_OFF_LEN_CODE    7'h2B
`define PWF_OFF_PAY7        7'h2C
`define PWF_OFF_PAY6        7'h2D
`define PWF_OFF_PAY5        7'h2E
`define PWF_OFF_PAY4        7'h2F
`define PWF_OFF_PAY3        7'h30
`define PWF_RST_BYTE        8'h00
`define PWF_MASK_LO_FIELD   6:2
`define PWF_LEN_FIELD       3:0
`define PWF_LEN_FULL        4'h8
`define PWF_ID_STD_LSB      18
`define PWF_ID_STD_W        11
`define PWF_NUM_PAY         8
`endif

// [logic/pwf_pkg.sv]
// types shared by the wake filter files
package pwf_pkg;
    typedef logic [7:0]  pwf_byte_t;
    typedef logic [28:0] pwf_id_t;
    typedef logic [3:0]  pwf_len_t;
    typedef enum logic [1:0] {
        PWF_IDLE,
        PWF_CHECK,
        PWF_DONE
    } pwf_state_t;
endpackage

// [logic/pwf_len_decode.sv]
// length code to payload byte count decoder
`include "pwf_map.svh"
module pwf_len_decode (
    input  wire pwf_pkg::pwf_len_t code_i,
    output logic [3:0]             bytes_o
);
    import pwf_pkg::*;
    // codes of eight and above all mean a full eight byte payload
    always_comb begin
        if (code_i[3]) begin
            bytes_o = `PWF_LEN_FULL;
        end else begin
            bytes_o = code_i;
        end
    end
endmodule

// [logic/pwf_payload_cmp.sv]
// per byte payload comparison within the decoded length
`include "pwf_map.svh"
module pwf_payload_cmp (
    input  wire logic [63:0] rx_payload_i,
    input  wire logic [63:0] cfg_payload_i,
    input  wire logic [3:0]  byte_cnt_i,
    output logic             equal_o
);
    import pwf_pkg::*;
    logic [`PWF_NUM_PAY-1:0] byte_ok;
    // byte k counts only when it lies inside the payload length
    genvar k;
    generate
        for (k = 0; k < `PWF_NUM_PAY; k++) begin : g_byte
            assign byte_ok[k] = (4'(k) >= byte_cnt_i) ||
                (rx_payload_i[k*8 +: 8] == cfg_payload_i[k*8 +: 8]);
        end
    endgenerate
    assign equal_o = &byte_ok;
endmodule

// [logic/pwf_filter.sv]
// partial wake frame filter: configuration store and frame compare
//
// Function
// - mask one compares bit, zero ignores
// - three full mask bytes for ids 28..5
// - low mask in bits 6:2, 1:0 reserved
// - reserved bits drop writes, read zero
// - length code four bits, 7:4 reserved
// - codes one to seven, eight up mean eight
// - code zero means empty payload, cleared value
// - length code must match all four bits
// - payload registers hold one byte, bit0 lsb
// - reset clears mask, length, payload registers
// - valid flag gates matching, cleared on events
// - standard ids compare positions 28 to 18
`include "pwf_map.svh"
module pwf_filter (
    input  wire logic                   sys_clk_i,
    input  wire logic                   rst_n_i,
    input  wire logic                   reg_wr_i,
    input  wire logic [`PWF_ADDR_W-1:0] reg_addr_i,
    input  wire pwf_pkg::pwf_byte_t     reg_wdata_i,
    output pwf_pkg::pwf_byte_t          reg_rdata_o,
    output logic                        reg_hit_o,
    input  wire logic                   cfg_valid_set_i,
    input  wire logic                   other_cfg_wr_i,
    input  wire pwf_pkg::pwf_id_t       cfg_id_i,
    input  wire logic                   cfg_ext_i,
    input  wire logic [23:0]            cfg_pay_low_i,
    input  wire logic                   rx_valid_i,
    input  wire pwf_pkg::pwf_id_t       rx_id_i,
    input  wire logic                   rx_ext_i,
    input  wire logic                   rx_remote_i,
    input  wire pwf_pkg::pwf_len_t      rx_len_i,
    input  wire logic [63:0]            rx_payload_i,
    output logic                        config_valid_flag_o,
    output logic                        wake_frame_match_o,
    output logic                        busy_o
);
    import pwf_pkg::*;

    pwf_byte_t  mask_hi_reg;
    pwf_byte_t  mask_midhi_reg;
    pwf_byte_t  mask_midlo_reg;
    logic [4:0] mask_lo_reg;
    pwf_len_t   len_code_reg;
    pwf_byte_t  pay_reg [3:7];
    logic       valid_reg;
    pwf_state_t state_reg;
    logic       match_reg;
    pwf_id_t    rx_id_reg;
    logic       rx_ext_reg;
    logic       rx_remote_reg;
    pwf_len_t   rx_len_reg;
    logic [63:0] rx_pay_reg;

    // decode of a mapped address, used by writes and reads
    function automatic logic is_mapped(input logic [`PWF_ADDR_W-1:0] a);
        is_mapped = (a >= `PWF_OFF_MASK_HI) && (a <= `PWF_OFF_PAY3);
    endfunction

    // write strobe into this block's registers
    logic wr_hit;
    assign wr_hit = reg_wr_i && is_mapped(reg_addr_i);

    // mask registers; reserved low-mask bits are simply not stored
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            mask_hi_reg    <= `PWF_RST_BYTE;
            mask_midhi_reg <= `PWF_RST_BYTE;
            mask_midlo_reg <= `PWF_RST_BYTE;
            mask_lo_reg    <= '0;
        end else if (reg_wr_i) begin
            unique case (reg_addr_i)
                `PWF_OFF_MASK_HI:    mask_hi_reg    <= reg_wdata_i;
                `PWF_OFF_MASK_MIDHI: mask_midhi_reg <= reg_wdata_i;
                `PWF_OFF_MASK_MIDLO: mask_midlo_reg <= reg_wdata_i;
                `PWF_OFF_MASK_LO: begin
                    mask_lo_reg <= reg_wdata_i[`PWF_MASK_LO_FIELD];
                end
                default: ;
            endcase
        end
    end

    // length code register, upper nibble discarded
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            len_code_reg <= '0;
        end else if (reg_wr_i && reg_addr_i == `PWF_OFF_LEN_CODE) begin
            len_code_reg <= reg_wdata_i[`PWF_LEN_FIELD];
        end
    end

    // payload pattern bytes 7 down to 3, one register each
    genvar g;
    generate
        for (g = 3; g <= 7; g++) begin : g_pay
            localparam logic [`PWF_ADDR_W-1:0] OFF =
                `PWF_OFF_PAY7 + 7'(7 - g);
            always_ff @(posedge sys_clk_i) begin
                if (!rst_n_i) begin
                    pay_reg[g] <= `PWF_RST_BYTE;
                end else if (reg_wr_i && reg_addr_i == OFF) begin
                    pay_reg[g] <= reg_wdata_i;
                end
            end
        end
    endgenerate

    // valid flag: clears win over a set in the same cycle, since a
    // config change must never leave a stale pattern armed
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            valid_reg <= 1'b0;
        end else if (wr_hit || other_cfg_wr_i || match_reg) begin
            valid_reg <= 1'b0;
        end else if (cfg_valid_set_i) begin
            valid_reg <= 1'b1;
        end
    end

    // read mux, reserved positions come back as zero
    always_comb begin
        reg_rdata_o = '0;
        unique case (reg_addr_i)
            `PWF_OFF_MASK_HI:    reg_rdata_o = mask_hi_reg;
            `PWF_OFF_MASK_MIDHI: reg_rdata_o = mask_midhi_reg;
            `PWF_OFF_MASK_MIDLO: reg_rdata_o = mask_midlo_reg;
            // reserved mask positions 7, 1 and 0 read back as zero
            `PWF_OFF_MASK_LO:    reg_rdata_o = {1'b0, mask_lo_reg, 2'b00};
            `PWF_OFF_LEN_CODE:   reg_rdata_o = {4'h0, len_code_reg};
            `PWF_OFF_PAY7:       reg_rdata_o = pay_reg[7];
            `PWF_OFF_PAY6:       reg_rdata_o = pay_reg[6];
            `PWF_OFF_PAY5:       reg_rdata_o = pay_reg[5];
            `PWF_OFF_PAY4:       reg_rdata_o = pay_reg[4];
            `PWF_OFF_PAY3:       reg_rdata_o = pay_reg[3];
            default:             reg_rdata_o = '0;
        endcase
    end
    assign reg_hit_o = is_mapped(reg_addr_i);

    // capture the received frame so the compare sees stable fields
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            rx_id_reg     <= '0;
            rx_ext_reg    <= 1'b0;
            rx_remote_reg <= 1'b0;
            rx_len_reg    <= '0;
            rx_pay_reg    <= '0;
        end else if (rx_valid_i && state_reg == PWF_IDLE) begin
            rx_id_reg     <= rx_id_i;
            rx_ext_reg    <= rx_ext_i;
            rx_remote_reg <= rx_remote_i;
            rx_len_reg    <= rx_len_i;
            rx_pay_reg    <= rx_payload_i;
        end
    end

    // full identifier mask, one per id bit 28..0
    pwf_id_t id_mask;
    assign id_mask = {mask_hi_reg, mask_midhi_reg, mask_midlo_reg,
                      mask_lo_reg};

    // identifier compare; a standard frame uses only 28..18
    logic [28:0] id_diff;
    logic        id_ok;
    logic [28:0] std_sel;
    assign id_diff = (rx_id_reg ^ cfg_id_i) & id_mask;
    assign std_sel = {{`PWF_ID_STD_W{1'b1}},
                      {`PWF_ID_STD_LSB{1'b0}}};
    always_comb begin
        if (cfg_ext_i) begin
            id_ok = (id_diff == '0);
        end else begin
            id_ok = ((id_diff & std_sel) == '0);
        end
    end

    // payload compare over the decoded byte count
    logic [3:0]  byte_cnt;
    logic        pay_ok;
    logic [63:0] cfg_pay;
    assign cfg_pay = {pay_reg[7], pay_reg[6], pay_reg[5], pay_reg[4],
                      pay_reg[3], cfg_pay_low_i};

    pwf_len_decode u_len (
        .code_i  (len_code_reg),
        .bytes_o (byte_cnt)
    );

    pwf_payload_cmp u_pay (
        .rx_payload_i  (rx_pay_reg),
        .cfg_payload_i (cfg_pay),
        .byte_cnt_i    (byte_cnt),
        .equal_o       (pay_ok)
    );

    // overall decision; remote frames never wake
    logic frame_ok;
    assign frame_ok = id_ok && (rx_len_reg == len_code_reg)
                   && pay_ok && !rx_remote_reg
                   && (rx_ext_reg == cfg_ext_i);

    // capture, check, report: one frame at a time
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            state_reg <= PWF_IDLE;
        end else begin
            unique case (state_reg)
                PWF_IDLE:  if (rx_valid_i) state_reg <= PWF_CHECK;
                PWF_CHECK: state_reg <= PWF_DONE;
                PWF_DONE:  state_reg <= PWF_IDLE;
            endcase
        end
    end

    // match pulse only while the configuration is valid
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            match_reg <= 1'b0;
        end else begin
            match_reg <= (state_reg == PWF_CHECK) && frame_ok
                      && valid_reg;
        end
    end

    assign config_valid_flag_o = valid_reg;
    assign wake_frame_match_o  = match_reg;
    assign busy_o              = (state_reg != PWF_IDLE);
endmodule

// [verif/pwf_filter_monitor.sv]
// port assertions for the wake filter
`include "pwf_map.svh"
module pwf_filter_monitor (
    input wire logic                   sys_clk_i,
    input wire logic                   rst_n_i,
    input wire logic                   reg_wr_i,
    input wire logic [`PWF_ADDR_W-1:0] reg_addr_i,
    input wire pwf_pkg::pwf_byte_t     reg_rdata_o,
    input wire logic                   reg_hit_o,
    input wire logic                   cfg_valid_set_i,
    input wire logic                   other_cfg_wr_i,
    input wire logic                   rx_valid_i,
    input wire logic                   busy_o,
    input wire logic                   config_valid_flag_o,
    input wire logic                   wake_frame_match_o
);
    import pwf_pkg::*;
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (!rst_n_i);
    property p_mask_rsvd;
        reg_addr_i == `PWF_OFF_MASK_LO |-> (reg_rdata_o & 8'h83) == 8'h00;
    endproperty
    a_mask_rsvd: assert property (p_mask_rsvd) else $error("mask bits");
    property p_len_rsvd;
        reg_addr_i == `PWF_OFF_LEN_CODE |-> reg_rdata_o[7:4] == 4'h0;
    endproperty
    a_len_rsvd: assert property (p_len_rsvd) else $error("len bits");
    property p_clr_wr;
        reg_wr_i && reg_hit_o |=> !config_valid_flag_o;
    endproperty
    a_clr_wr: assert property (p_clr_wr) else $error("flag kept");
    property p_clr_other;
        other_cfg_wr_i |=> !config_valid_flag_o;
    endproperty
    a_clr_other: assert property (p_clr_other) else $error("flag kept");
    // clears win over a set in the same cycle, so only a lone set counts
    property p_set;
        cfg_valid_set_i && !reg_wr_i && !other_cfg_wr_i
            && !wake_frame_match_o |=> config_valid_flag_o;
    endproperty
    a_set: assert property (p_set) else $error("flag not set");
    property p_gate;
        wake_frame_match_o |-> $past(config_valid_flag_o);
    endproperty
    a_gate: assert property (p_gate) else $error("match unarmed");
    property p_one_shot;
        wake_frame_match_o |=> !config_valid_flag_o && !wake_frame_match_o;
    endproperty
    a_one_shot: assert property (p_one_shot) else $error("no clear");
    property p_take;
        wake_frame_match_o |-> $past(rx_valid_i && !busy_o, 2) && busy_o;
    endproperty
    a_take: assert property (p_take) else $error("match timing");
endmodule
bind pwf_filter pwf_filter_monitor u_mon (.*);

// [verif/pwf_host_model.sv]
// host model driving the register port and flag commands
`include "pwf_map.svh"
module pwf_host_model (
    input  wire logic              sys_clk_i,
    input  wire pwf_pkg::pwf_byte_t reg_rdata_i,
    output logic                   reg_wr_o,
    output logic [`PWF_ADDR_W-1:0] reg_addr_o,
    output pwf_pkg::pwf_byte_t     reg_wdata_o,
    output logic                   cfg_valid_set_o,
    output logic                   other_cfg_wr_o
);
    timeunit 1ns;
    timeprecision 100ps;
    import pwf_pkg::*;
    initial begin
        reg_wr_o = 1'b0;
        reg_addr_o = 7'h00;
        reg_wdata_o = 8'h00;
        cfg_valid_set_o = 1'b0;
        other_cfg_wr_o = 1'b0;
    end
    // data inverted after the strobe so a stale byte never looks valid
    task automatic wr(input logic [6:0] a, input pwf_byte_t d);
        @(posedge sys_clk_i) #1;
        reg_wr_o = 1'b1;
        reg_addr_o = a;
        reg_wdata_o = d;
        @(posedge sys_clk_i) #1;
        reg_wr_o = 1'b0;
        reg_wdata_o = ~d;
    endtask
    // read data is combinational, let it settle after the address
    task automatic rd(input logic [6:0] a, output pwf_byte_t d);
        @(posedge sys_clk_i) #1;
        reg_addr_o = a;
        #1 d = reg_rdata_i;
    endtask
    // s low arms the pattern, s high touches other config data
    task automatic pulse(input logic s);
        @(posedge sys_clk_i) #1;
        cfg_valid_set_o = !s;
        other_cfg_wr_o = s;
        @(posedge sys_clk_i) #1;
        cfg_valid_set_o = 1'b0;
        other_cfg_wr_o = 1'b0;
    endtask
    // no remote request pattern is ever configured
endmodule

// [verif/testbench.sv]
// self-checking bench for the wake filter
`include "pwf_map.svh"
module testbench;
    timeunit 1ns;
    timeprecision 100ps;
    import pwf_pkg::*;
    logic sys_clk_i, rst_n_i, reg_wr_i, reg_hit_o, cfg_valid_set_i;
    logic other_cfg_wr_i, cfg_ext_i, rx_valid_i, rx_ext_i, rx_remote_i;
    logic busy_o, config_valid_flag_o, wake_frame_match_o;
    logic [`PWF_ADDR_W-1:0] reg_addr_i;
    pwf_byte_t              reg_wdata_i, reg_rdata_o;
    pwf_id_t                cfg_id_i, rx_id_i;
    pwf_len_t               rx_len_i;
    logic [23:0]            cfg_pay_low_i;
    logic [63:0]            rx_payload_i, pat;
    int                     mismatches, cmp_count, cycles;
    pwf_filter dut (.*);
    pwf_host_model host (.sys_clk_i, .reg_rdata_i(reg_rdata_o),
        .reg_wr_o(reg_wr_i), .reg_addr_o(reg_addr_i),
        .reg_wdata_o(reg_wdata_i), .cfg_valid_set_o(cfg_valid_set_i),
        .other_cfg_wr_o(other_cfg_wr_i));
    task automatic chk(input string n, input logic [63:0] e, g);
        cmp_count++;
        if (g !== e) begin
            mismatches++;
            $display("Error %s expected %0h seen %0h", n, e, g);
        end
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    // one frame, match looked at in its single high cycle
    task automatic frame(input logic v, pwf_id_t id, pwf_len_t n,
                         input logic [63:0] p, input logic r, e);
        if (v)
            host.pulse(1'b0);
        @(posedge sys_clk_i) #1;
        {rx_id_i, rx_len_i, rx_payload_i, rx_remote_i} = {id, n, p, r};
        rx_valid_i = 1'b1;
        @(posedge sys_clk_i) #1;
        rx_valid_i = 1'b0;
        @(posedge sys_clk_i) #2;
        chk("match", e, wake_frame_match_o);
    endtask
    task automatic t_regs();
        pwf_byte_t d;
        for (int i = 0; i < 10; i++) begin
            host.rd(`PWF_OFF_MASK_HI + 7'(i), d);
            chk("reset", 8'h00, d);
            host.wr(`PWF_OFF_MASK_HI + 7'(i), 8'hFF);
            host.rd(`PWF_OFF_MASK_HI + 7'(i), d);
            chk("ones", i == 3 ? 8'h7C : i == 4 ? 8'h0F : 8'hFF, d);
        end
        host.wr(7'h31, 8'hFF);
        host.rd(7'h31, d);
        chk("unmapped", 9'h000, {reg_hit_o, d});
        host.pulse(1'b0);
        chk("flag", 1'b1, config_valid_flag_o);
        host.wr(`PWF_OFF_PAY3, 8'h55);
        chk("flag wr", 1'b0, config_valid_flag_o);
        host.pulse(1'b0);
        host.pulse(1'b1);
        chk("flag other", 1'b0, config_valid_flag_o);
    endtask
    task automatic t_match();
        pwf_byte_t c [10] = '{8'hFF, 8'hE0, 8'hFF, 8'h7C, 8'h04,
                              8'h11, 8'h22, 8'h33, 8'h44, 8'h55};
        pwf_id_t   k = 29'h1ABCDE12;
        for (int i = 0; i < 10; i++)
            host.wr(`PWF_OFF_MASK_HI + 7'(i), c[i]);
        {cfg_ext_i, rx_ext_i} = 2'b11;
        {cfg_id_i, cfg_pay_low_i} = {k, 24'hC0FFEE};
        pat = 64'h11223344_55C0FFEE;
        frame(1, k, 4'h4, pat ^ 64'hFF_0000_0000, 0, 1);
        frame(1, k, 4'h4, pat ^ 64'h0100_0000, 0, 0);
        frame(1, k ^ 29'h10, 4'h4, pat, 0, 0);
        frame(1, k ^ 29'h2000, 4'h4, pat, 0, 1);
        frame(1, k, 4'h4, pat, 1, 0);
        // a remote frame leaves the flag armed, so disarm it first
        host.pulse(1'b1);
        frame(0, k, 4'h4, pat, 0, 0);
        host.wr(`PWF_OFF_LEN_CODE, 8'h08);
        frame(1, k, 4'hC, pat, 0, 0);
        frame(1, k, 4'h8, pat, 0, 1);
        {cfg_ext_i, rx_ext_i} = 2'b00;
        frame(1, k ^ 29'h1, 4'h8, pat, 0, 1);
        frame(1, k ^ 29'h40000, 4'h8, pat, 0, 0);
        host.wr(`PWF_OFF_LEN_CODE, 8'h00);
        frame(1, k, 4'h0, ~pat, 0, 1);
    endtask
    initial begin
        sys_clk_i = 1'b0;
        forever #2.5 sys_clk_i = ~sys_clk_i;
    end
    // hang guard well above the roughly 130 cycles needed
    always @(posedge sys_clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            mismatches++;
            summarize();
        end
    end
    initial begin
        {rst_n_i, cfg_ext_i, rx_valid_i, rx_ext_i, rx_remote_i} = 5'h00;
        {cfg_id_i, rx_id_i, rx_len_i, cfg_pay_low_i, rx_payload_i} = '0;
        {mismatches, cmp_count, cycles} = '0;
        repeat (3) @(posedge sys_clk_i);
        #1 rst_n_i = 1'b1;
        t_regs();
        t_match();
        summarize();
    end
endmodule
